// file: hdl/ch23_cfg_regs.vh
// Purpose: register map constants for the channel 2/3 configuration block
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: printed offsets are register indices; byte address is index * 4
`ifndef CH23_CFG_REGS_VH
`define CH23_CFG_REGS_VH

`define CH3_CTL_INDEX 8'h23
`define CH23_DIV_INDEX 8'h24
`define CH2_CTL_INDEX 8'h22
`define CH3_CTL_ADDR 12'h08c
`define CH23_DIV_ADDR 12'h090
`define CH2_CTL_ADDR 12'h088

`define CH3_FMT_HI 6
`define CH3_FMT_LO 5
`define CH3_DRVA_HI 4
`define CH3_DRVA_LO 3
`define CH3_DRVB_HI 2
`define CH3_DRVB_LO 1
`define CH23_SRC_BIT 7

`define CH3_FMT_RST 2'h1
`define CH3_DRVA_RST 2'h2
`define CH3_DRVB_RST 2'h0
`define CH23_SRC_RST 1'h1
`define CH23_DIV_RST 8'h03

`define FMT_OFF 2'h0
`define FMT_AC_DIFF 2'h1
`define FMT_HCSL 2'h2
`define FMT_CMOS 2'h3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: hdl/ch23_divider.v
// Purpose: divides the selected channel 2/3 source clock enable by n+1
// Assumes: source arrives as a one-cycle enable pulse on i_clk
// Notes: a new ratio is compared from the next source pulse; the count is not restarted
`timescale 1ns/100ps
`default_nettype none
module ch23_divider #(
	parameter WIDTH = 8
) (
	input wire i_clk,
	input wire i_arst_n,
	input wire i_src_en,
	input wire [WIDTH-1:0] i_div,
	output reg o_tick
);
	reg [WIDTH-1:0] count_reg;
	// stored n gives ratio n+1, so n=0 passes every source pulse
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count_reg <= {WIDTH{1'b0}};
			o_tick <= 1'b0;
		end else begin
			o_tick <= 1'b0;
			if (i_src_en) begin
				if (count_reg >= i_div) begin
					count_reg <= {WIDTH{1'b0}};
					o_tick <= 1'b1;
				end else begin
					count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/ch23_cfg.v
// Purpose: channel 3 driver control and shared channel 2/3 divider
// Assumes: AXI4-Lite master issues at most one read and one write at once
// Notes: synthesizer clocks arrive as enables from other logic on i_clk
//
// Summary of operation
// - channel 3 format resets to one, four modes
// - drive setting a, bits 4:3, resets to two
// - drive setting b, bits 2:1, resets to zero
// - eight-bit divider value n divides by n+1
// - one divider shared by both channels, reset three
// - source select bit picks synthesizer, resets one
//
// The AXI4-Lite slave port was chosen for this implementation.
`include "ch23_cfg_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module ch23_cfg #(
	parameter DIV_WIDTH = 8
) (
	input wire i_clk,
	input wire i_arst_n,
	input wire [11:0] i_s_axi_awaddr,
	input wire i_s_axi_awvalid,
	output reg o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	output reg o_s_axi_wready,
	output reg [1:0] o_s_axi_bresp,
	output reg o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire [11:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	output reg o_s_axi_arready,
	output reg [31:0] o_s_axi_rdata,
	output reg [1:0] o_s_axi_rresp,
	output reg o_s_axi_rvalid,
	input wire i_s_axi_rready,
	input wire i_first_synth_en,
	input wire i_second_synth_en,
	output reg [1:0] o_ch3_format,
	output reg [1:0] o_ch3_drive_setting_a,
	output reg [1:0] o_ch3_drive_setting_b,
	output reg o_ch3_enable,
	output reg o_ch3_cmos,
	output reg o_ch23_source_select,
	output reg [DIV_WIDTH-1:0] o_ch23_divider,
	output reg o_ch23_tick
);
	reg [1:0] fmt_reg;
	reg [1:0] drva_reg;
	reg [1:0] drvb_reg;
	reg src_reg;
	reg [DIV_WIDTH-1:0] div_reg;
	reg [11:0] awaddr_reg;
	reg aw_held_reg;
	reg [7:0] wdata_reg;
	reg w_held_reg;
	reg wstrb_reg;
	reg src_en_reg;
	wire div_tick;
	wire do_write;
	wire [11:0] wr_addr;
	wire [7:0] wr_byte;
	wire wr_lane;
	reg [31:0] rd_word;
	reg rd_hit;

	// address and data may be taken in either order; hold until both
	assign wr_addr = aw_held_reg ? awaddr_reg : i_s_axi_awaddr;
	assign wr_byte = w_held_reg ? wdata_reg : i_s_axi_wdata[7:0];
	assign wr_lane = w_held_reg ? wstrb_reg : i_s_axi_wstrb[0];
	assign do_write = !o_s_axi_bvalid &&
		(aw_held_reg || (i_s_axi_awvalid && o_s_axi_awready)) &&
		(w_held_reg || (i_s_axi_wvalid && o_s_axi_wready));

	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fmt_reg <= `CH3_FMT_RST;
			drva_reg <= `CH3_DRVA_RST;
			drvb_reg <= `CH3_DRVB_RST;
			src_reg <= `CH23_SRC_RST;
			div_reg <= `CH23_DIV_RST;
			awaddr_reg <= 12'h000;
			aw_held_reg <= 1'b0;
			wdata_reg <= 8'h00;
			wstrb_reg <= 1'b0;
			w_held_reg <= 1'b0;
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= `RESP_OKAY;
		end else begin
			o_s_axi_awready <= !aw_held_reg && !o_s_axi_bvalid &&
				!(i_s_axi_awvalid && o_s_axi_awready);
			o_s_axi_wready <= !w_held_reg && !o_s_axi_bvalid &&
				!(i_s_axi_wvalid && o_s_axi_wready);
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				awaddr_reg <= i_s_axi_awaddr;
				aw_held_reg <= 1'b1;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				wdata_reg <= i_s_axi_wdata[7:0];
				wstrb_reg <= i_s_axi_wstrb[0];
				w_held_reg <= 1'b1;
			end
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_awready <= 1'b0;
				o_s_axi_wready <= 1'b0;
				o_s_axi_bresp <= `RESP_OKAY;
				case (wr_addr)
				`CH3_CTL_ADDR: begin
					// bits 7 and 0 have no storage
					if (wr_lane) begin
						fmt_reg <= wr_byte[`CH3_FMT_HI:`CH3_FMT_LO];
						drva_reg <= wr_byte[`CH3_DRVA_HI:`CH3_DRVA_LO];
						drvb_reg <= wr_byte[`CH3_DRVB_HI:`CH3_DRVB_LO];
					end
				end
				`CH23_DIV_ADDR: begin
					if (wr_lane) begin
						div_reg <= wr_byte[DIV_WIDTH-1:0];
					end
				end
				`CH2_CTL_ADDR: begin
					if (wr_lane) begin
						src_reg <= wr_byte[`CH23_SRC_BIT];
					end
				end
				default: begin
					o_s_axi_bresp <= `RESP_SLVERR;
				end
				endcase
			end else if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @* begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		case (i_s_axi_araddr)
		`CH3_CTL_ADDR: begin
			rd_word[`CH3_FMT_HI:`CH3_FMT_LO] = fmt_reg;
			rd_word[`CH3_DRVA_HI:`CH3_DRVA_LO] = drva_reg;
			rd_word[`CH3_DRVB_HI:`CH3_DRVB_LO] = drvb_reg;
		end
		`CH23_DIV_ADDR: begin
			rd_word[DIV_WIDTH-1:0] = div_reg;
		end
		`CH2_CTL_ADDR: begin
			rd_word[`CH23_SRC_BIT] = src_reg;
		end
		default: begin
			rd_hit = 1'b0;
		end
		endcase
	end

	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h00000000;
			o_s_axi_rresp <= `RESP_OKAY;
		end else begin
			o_s_axi_arready <= !o_s_axi_rvalid &&
				!(i_s_axi_arvalid && o_s_axi_arready);
			if (i_s_axi_arvalid && o_s_axi_arready) begin
				o_s_axi_arready <= 1'b0;
				o_s_axi_rvalid <= 1'b1;
				o_s_axi_rdata <= rd_word;
				o_s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (o_s_axi_rvalid && i_s_axi_rready) begin
				o_s_axi_rvalid <= 1'b0;
			end
		end
	end

	// source select picks which synthesizer enable feeds the divider
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			src_en_reg <= 1'b0;
		end else begin
			src_en_reg <= src_reg ? i_second_synth_en : i_first_synth_en;
		end
	end

	// a single divider instance serves channels 2 and 3 alike
	ch23_divider #(
		.WIDTH(DIV_WIDTH)
	) u_div (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_src_en(src_en_reg),
		.i_div(div_reg),
		.o_tick(div_tick)
	);

	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_ch3_format <= `CH3_FMT_RST;
			o_ch3_drive_setting_a <= `CH3_DRVA_RST;
			o_ch3_drive_setting_b <= `CH3_DRVB_RST;
			o_ch3_enable <= 1'b1;
			o_ch3_cmos <= 1'b0;
			o_ch23_source_select <= `CH23_SRC_RST;
			o_ch23_divider <= `CH23_DIV_RST;
			o_ch23_tick <= 1'b0;
		end else begin
			o_ch3_format <= fmt_reg;
			o_ch3_drive_setting_a <= drva_reg;
			o_ch3_drive_setting_b <= drvb_reg;
			// drive settings mean current/load when differential, pin state when cmos
			o_ch3_enable <= (fmt_reg != `FMT_OFF);
			o_ch3_cmos <= (fmt_reg == `FMT_CMOS);
			o_ch23_source_select <= src_reg;
			o_ch23_divider <= div_reg;
			o_ch23_tick <= div_tick && (fmt_reg != `FMT_OFF);
		end
	end
endmodule
`default_nettype wire

// file: bench/ch23_cfg_asserts.sv
// Purpose: port checks for ch23_cfg
// Assumes: one clock, async low reset
// Notes: reset values seen at first edge after release
`timescale 1ns/100ps
`default_nettype none
module ch23_cfg_asserts #(
	parameter DIV_WIDTH = 8
) (
	input wire i_clk,
	input wire i_arst_n,
	input wire [1:0] o_ch3_format,
	input wire [1:0] o_ch3_drive_setting_a,
	input wire [1:0] o_ch3_drive_setting_b,
	input wire o_ch3_enable,
	input wire o_ch3_cmos,
	input wire o_ch23_source_select,
	input wire [DIV_WIDTH-1:0] o_ch23_divider,
	input wire o_ch23_tick,
	input wire o_s_axi_rvalid,
	input wire [1:0] o_s_axi_rresp,
	input wire [31:0] o_s_axi_rdata
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_rel;
		$rose(i_arst_n);
	endsequence
	property p_fmt;
		o_ch3_enable == (o_ch3_format != 2'h0) &&
			o_ch3_cmos == (o_ch3_format == 2'h3);
	endproperty
	property p_rst_a;
		s_rel |-> o_ch3_drive_setting_a == 2'h2 && o_ch3_format == 2'h1;
	endproperty
	property p_rst_b;
		s_rel |-> o_ch3_drive_setting_b == 2'h0;
	endproperty
	// a ratio above one cannot give two ticks back to back
	property p_tick;
		o_ch23_tick && o_ch23_divider != 'h0 |=> !o_ch23_tick;
	endproperty
	property p_rst_div;
		s_rel |-> o_ch23_divider == 'h3;
	endproperty
	property p_rst_src;
		s_rel |-> o_ch23_source_select;
	endproperty
	property p_upper;
		o_s_axi_rvalid && o_s_axi_rresp == 2'h0 |-> o_s_axi_rdata[31:8] == 0;
	endproperty
	a_fmt: assert property (p_fmt) else $error("format flags wrong");
	a_rst_a: assert property (p_rst_a) else $error("drive a reset");
	a_rst_b: assert property (p_rst_b) else $error("drive b reset");
	a_tick: assert property (p_tick) else $error("tick too soon");
	a_rst_div: assert property (p_rst_div) else $error("div reset");
	a_rst_src: assert property (p_rst_src) else $error("src reset");
	a_upper: assert property (p_upper) else $error("upper bits set");
endmodule
bind ch23_cfg ch23_cfg_asserts #(
	.DIV_WIDTH(DIV_WIDTH)
) u_chk (
	.i_clk(i_clk),
	.i_arst_n(i_arst_n),
	.o_ch3_format(o_ch3_format),
	.o_ch3_drive_setting_a(o_ch3_drive_setting_a),
	.o_ch3_drive_setting_b(o_ch3_drive_setting_b),
	.o_ch3_enable(o_ch3_enable),
	.o_ch3_cmos(o_ch3_cmos),
	.o_ch23_source_select(o_ch23_source_select),
	.o_ch23_divider(o_ch23_divider),
	.o_ch23_tick(o_ch23_tick),
	.o_s_axi_rvalid(o_s_axi_rvalid),
	.o_s_axi_rresp(o_s_axi_rresp),
	.o_s_axi_rdata(o_s_axi_rdata)
);
`default_nettype wire

// file: bench/ch23_cfg_tb.sv
// Purpose: register and divider bench for ch23_cfg
// Assumes: register map header constants
// Notes: tick count checks source select and ratio
`include "ch23_cfg_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module ch23_cfg_tb;
	logic i_clk = 0, i_arst_n = 0, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0;
	logic [11:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
	logic [31:0] i_s_axi_wdata = 0, o_s_axi_rdata;
	logic [3:0] i_s_axi_wstrb = 0;
	logic i_s_axi_bready = 0, i_s_axi_arvalid = 0, i_s_axi_rready = 0;
	logic i_first_synth_en = 0, i_second_synth_en = 0, o_ch23_tick;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
	logic o_s_axi_rvalid, o_ch3_enable, o_ch3_cmos, o_ch23_source_select;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp, o_ch3_format;
	logic [1:0] o_ch3_drive_setting_a, o_ch3_drive_setting_b;
	logic [7:0] o_ch23_divider;
	int err_total = 0, n_compared = 0, ticks = 0;
	ch23_cfg DUT (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_s_axi_awaddr(i_s_axi_awaddr),
		.i_s_axi_awvalid(i_s_axi_awvalid),
		.o_s_axi_awready(o_s_axi_awready),
		.i_s_axi_wdata(i_s_axi_wdata),
		.i_s_axi_wstrb(i_s_axi_wstrb),
		.i_s_axi_wvalid(i_s_axi_wvalid),
		.o_s_axi_wready(o_s_axi_wready),
		.o_s_axi_bresp(o_s_axi_bresp),
		.o_s_axi_bvalid(o_s_axi_bvalid),
		.i_s_axi_bready(i_s_axi_bready),
		.i_s_axi_araddr(i_s_axi_araddr),
		.i_s_axi_arvalid(i_s_axi_arvalid),
		.o_s_axi_arready(o_s_axi_arready),
		.o_s_axi_rdata(o_s_axi_rdata),
		.o_s_axi_rresp(o_s_axi_rresp),
		.o_s_axi_rvalid(o_s_axi_rvalid),
		.i_s_axi_rready(i_s_axi_rready),
		.i_first_synth_en(i_first_synth_en),
		.i_second_synth_en(i_second_synth_en),
		.o_ch3_format(o_ch3_format),
		.o_ch3_drive_setting_a(o_ch3_drive_setting_a),
		.o_ch3_drive_setting_b(o_ch3_drive_setting_b),
		.o_ch3_enable(o_ch3_enable),
		.o_ch3_cmos(o_ch3_cmos),
		.o_ch23_source_select(o_ch23_source_select),
		.o_ch23_divider(o_ch23_divider),
		.o_ch23_tick(o_ch23_tick)
	);
	always #2.5 i_clk = ~i_clk;
	always @(posedge i_clk) if (o_ch23_tick === 1'b1) ticks++;
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(logic [11:0] a, logic [7:0] d, logic [3:0] s,
		logic [1:0] r);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= {24'h0, d};
		i_s_axi_wstrb <= s;
		i_s_axi_awvalid <= 1;
		i_s_axi_wvalid <= 1;
		i_s_axi_bready <= 1;
		do begin
			@(posedge i_clk);
			if (o_s_axi_awready === 1'b1) i_s_axi_awvalid <= 0;
			if (o_s_axi_wready === 1'b1) i_s_axi_wvalid <= 0;
		end while (o_s_axi_bvalid !== 1'b1);
		i_s_axi_bready <= 0;
		chk("bresp", r, o_s_axi_bresp);
		@(posedge i_clk);
	endtask
	task automatic rd(logic [11:0] a, logic [7:0] e, logic [1:0] r);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1;
		i_s_axi_rready <= 1;
		do begin
			@(posedge i_clk);
			if (o_s_axi_arready === 1'b1) i_s_axi_arvalid <= 0;
		end while (o_s_axi_rvalid !== 1'b1);
		i_s_axi_rready <= 0;
		chk("rdata", {24'h0, e}, o_s_axi_rdata);
		chk("rresp", r, o_s_axi_rresp);
		@(posedge i_clk);
	endtask
	// only the line picked by f pulses; pulses come every cycle so a
	// divider that ignored its ratio would tick back to back
	task automatic pulse(logic f, int k);
		i_first_synth_en <= f;
		i_second_synth_en <= !f;
		repeat (k) @(posedge i_clk);
		i_first_synth_en <= 0;
		i_second_synth_en <= 0;
		repeat (4) @(posedge i_clk);
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#20000;
		err_total++;
		report_and_stop;
	end
	initial begin
		repeat (6) @(posedge i_clk);
		i_arst_n <= 1;
		@(posedge i_clk);
		rd(`CH3_CTL_ADDR, 8'h30, `RESP_OKAY);
		rd(`CH23_DIV_ADDR, 8'h03, `RESP_OKAY);
		rd(`CH2_CTL_ADDR, 8'h80, `RESP_OKAY);
		$display("reset test done");
		wr(`CH3_CTL_ADDR, 8'hff, 4'h1, `RESP_OKAY);
		rd(`CH3_CTL_ADDR, 8'h7e, `RESP_OKAY);
		for (int f = 0; f < 4; f++) begin
			wr(`CH3_CTL_ADDR, 8'(f * 42), 4'h1, `RESP_OKAY);
			rd(`CH3_CTL_ADDR, 8'(f * 42), `RESP_OKAY);
			chk("format", f, o_ch3_format);
			chk("drive_a", f, o_ch3_drive_setting_a);
			chk("drive_b", f, o_ch3_drive_setting_b);
			chk("enable", f != 0, o_ch3_enable);
			chk("cmos", f == 3, o_ch3_cmos);
		end
		wr(`CH23_DIV_ADDR, 8'hff, 4'h1, `RESP_OKAY);
		rd(`CH23_DIV_ADDR, 8'hff, `RESP_OKAY);
		wr(`CH23_DIV_ADDR, 8'h5a, 4'h0, `RESP_OKAY);
		wr(12'h000, 8'h11, 4'h1, `RESP_SLVERR);
		rd(12'h000, 8'h00, `RESP_SLVERR);
		rd(`CH23_DIV_ADDR, 8'hff, `RESP_OKAY);
		$display("register test done");
		wr(`CH2_CTL_ADDR, 8'h00, 4'h1, `RESP_OKAY);
		chk("source", 0, o_ch23_source_select);
		wr(`CH23_DIV_ADDR, 8'h02, 4'h1, `RESP_OKAY);
		chk("divider", 8'h02, o_ch23_divider);
		pulse(1, 9);
		chk("ticks", 3, ticks);
		pulse(0, 9);
		chk("ticks", 3, ticks);
		wr(`CH2_CTL_ADDR, 8'h80, 4'h1, `RESP_OKAY);
		pulse(0, 6);
		chk("ticks", 5, ticks);
		wr(`CH23_DIV_ADDR, 8'h00, 4'h1, `RESP_OKAY);
		pulse(0, 4);
		chk("ticks", 9, ticks);
		// a disabled channel 3 output must not pass divider ticks
		wr(`CH3_CTL_ADDR, 8'h00, 4'h1, `RESP_OKAY);
		pulse(0, 3);
		chk("ticks", 9, ticks);
		$display("divider test done");
		// move every field but drive setting b off its reset value, then reset in mid-run
		wr(`CH2_CTL_ADDR, 8'h00, 4'h1, `RESP_OKAY);
		i_arst_n <= 0;
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1;
		@(posedge i_clk);
		rd(`CH3_CTL_ADDR, 8'h30, `RESP_OKAY);
		rd(`CH23_DIV_ADDR, 8'h03, `RESP_OKAY);
		rd(`CH2_CTL_ADDR, 8'h80, `RESP_OKAY);
		$display("second reset test done");
		report_and_stop;
	end
endmodule
`default_nettype wire
